// File: hdl/irq_ctrl_pkg.sv
// Purpose: Shared constants for the prioritized interrupt controller.
// Assumes: One CPU clock of 20 MHz, byte-wide register port.
// Notes: Offsets are byte addresses on the plain register port.
package irq_ctrl_pkg;
  localparam int NUM_SRC = 11;
  localparam int PIN_W = 16;
  localparam logic [7:0] ADDR_GLOBAL_EN = 8'h20;
  localparam logic [7:0] ADDR_EP_EN = 8'h21;
  localparam logic [7:0] ADDR_PIN_EN0 = 8'h04;
  localparam logic [7:0] ADDR_PIN_EN1 = 8'h05;
  localparam logic [7:0] ADDR_PIN_POL0 = 8'h06;
  localparam logic [7:0] ADDR_PIN_POL1 = 8'h07;
  localparam logic [7:0] ADDR_CAP_EN = 8'h22;
  localparam logic [7:0] ADDR_STATUS = 8'hff;
  localparam logic [7:0] ADDR_PENDING_LO = 8'h23;
  localparam logic [7:0] ADDR_PENDING_HI = 8'h24;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int STATUS_GIE_BIT = 2;
  localparam int STATUS_PEND_BIT = 7;
  localparam int WAKE_EN_BIT = 7;
  localparam int GPIO_EN_BIT = 6;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] VECTOR_BASE = 16'h0002;
  localparam int CALL_CYCLES = 10;
  localparam int JUMP_CYCLES = 5;
  localparam int WAKE_PERIOD_US = 1024;
  localparam int CLK_MHZ = 20;
  localparam int WAKE_PERIOD_CYC = WAKE_PERIOD_US * CLK_MHZ;
  localparam int SRC_BUS = 0;
  localparam int SRC_T128 = 1;
  localparam int SRC_T1024 = 2;
  localparam int SRC_EP0 = 3;
  localparam int SRC_SPI = 6;
  localparam int SRC_CAPA = 7;
  localparam int SRC_CAPB = 8;
  localparam int SRC_GPIO = 9;
  localparam int SRC_WAKE = 10;
endpackage

// File: hdl/edge_sync.sv
// Purpose: Two-stage synchroniser with rise and fall pulses decoded from registered stages.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module edge_sync #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [W-1:0] pin_async,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_async;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = prev_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule // edge_sync

// File: hdl/irq_ctrl.sv
// Purpose: Eleven-source prioritized interrupt controller with vectoring.
// Assumes: The CPU sequencer reports instruction boundaries and flag state.
// Notes: Registers sit on a plain strobe port with read data one cycle later.
`timescale 1ns/1ps
module irq_ctrl #(
  parameter int WAKE_CYC = irq_ctrl_pkg::WAKE_PERIOD_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic bus_event,
  input wire logic tick_128us,
  input wire logic tick_1024us,
  input wire logic [2:0] ep_event,
  input wire logic spi_event,
  input wire logic [irq_ctrl_pkg::PIN_W-1:0] gpio_pin,
  input wire logic [1:0] cap_pin,
  input wire logic instr_done,
  input wire logic disable_irq_instr,
  input wire logic enable_irq_instr,
  input wire logic return_from_irq_instr,
  input wire logic [15:0] cpu_pc,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic [17:0] stack_pop_data,
  output logic irq_take,
  output logic [15:0] irq_vector,
  output logic [17:0] stack_push_data,
  output logic stack_push,
  output logic restore_valid,
  output logic [15:0] restore_pc,
  output logic restore_carry,
  output logic restore_zero,
  output logic [15:0] fetch_pc,
  output logic [4:0] ack_cycles,
  output logic wake_running
);
  import irq_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_CALL = 3'b010,
    ST_JUMP = 3'b100
  } ack_state_t;

  ack_state_t state_r;
  ack_state_t state_nxt;
  logic [7:0] global_en_r;
  logic [2:0] ep_en_r;
  logic [PIN_W-1:0] pin_en_r;
  logic [PIN_W-1:0] pin_pol_r;
  logic [3:0] cap_en_r;
  logic gie_r;
  logic [NUM_SRC-1:0] pending_r;
  logic [NUM_SRC-1:0] pending_nxt;
  logic [PIN_W-1:0] trig_lock_r;
  logic [31:0] wake_cnt_r;
  logic [4:0] cyc_r;
  logic [7:0] rdata_r;
  logic [15:0] vec_r;
  logic take_r;
  logic [17:0] push_r;
  logic push_r_v;
  logic [PIN_W-1:0] pin_lvl;
  logic [PIN_W-1:0] pin_rise;
  logic [PIN_W-1:0] pin_fall;
  logic [1:0] cap_rise;
  logic [1:0] cap_fall;

  // Lowest index wins; an index equal to NUM_SRC means nothing is requested.
  function automatic logic [3:0] pick_first(input logic [NUM_SRC-1:0] req);
    logic [3:0] idx;
    idx = 4'(NUM_SRC);
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Write strobes are decoded in one place so every write select uses the same compare.
  function automatic logic reg_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
    return strobe && (addr == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling.
  edge_sync #(.W(PIN_W)) u_gpio_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin_async(gpio_pin),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  edge_sync #(.W(2)) u_cap_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin_async(cap_pin),
    .level(),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Source events.
  wire [PIN_W-1:0] pin_edge = (pin_pol_r & pin_rise) | (~pin_pol_r & pin_fall);
  wire [PIN_W-1:0] pin_trig_lvl = ~(pin_pol_r ^ pin_lvl);
  wire [PIN_W-1:0] pin_hit = pin_edge & pin_en_r;
  // A lock stops blocking as soon as its pin is seen back at the idle level or is disabled.
  wire [PIN_W-1:0] lock_keep = trig_lock_r & pin_en_r & pin_trig_lvl;
  // A locked pin holds off every other pin; pins that edge in the same cycle fire once together and are all locked.
  wire gpio_blocked = |lock_keep;
  wire gpio_fire = global_en_r[GPIO_EN_BIT] & ~gpio_blocked & (|pin_hit);
  wire [PIN_W-1:0] lock_nxt = gpio_fire ? (pin_hit | lock_keep) : lock_keep;
  wire cap_a_fire = (cap_rise[0] & cap_en_r[0]) | (cap_fall[0] & cap_en_r[1]);
  wire cap_b_fire = (cap_rise[1] & cap_en_r[2]) | (cap_fall[1] & cap_en_r[3]);
  wire wake_fire = global_en_r[WAKE_EN_BIT] && (wake_cnt_r == 32'(WAKE_CYC - 1));
  // The counter clears on the fire cycle so the period stays exact.
  wire [31:0] wake_cnt_nxt = (!global_en_r[WAKE_EN_BIT] || wake_fire) ? 32'h0 : wake_cnt_r + 32'h1;
  // Bus, timer, endpoint and serial sources arrive as qualified one-cycle pulses.
  wire [NUM_SRC-1:0] src_event = {wake_fire, gpio_fire, cap_b_fire, cap_a_fire, spi_event,
                                  ep_event, tick_1024us, tick_128us, bus_event};
  wire [NUM_SRC-1:0] src_enable = {global_en_r[7:3], ep_en_r, global_en_r[2:0]};
  wire [NUM_SRC-1:0] request = pending_r & src_enable;
  wire [3:0] top_idx = pick_first(request);
  // Top priority is resolved every cycle; only the take edge uses it.
  wire any_req = |request;
  // Requests wait for the instruction boundary so a multi-cycle instruction is never split.
  wire take_now = (state_r == ST_RUN) && instr_done && gie_r && any_req;
  wire [15:0] top_vec = VECTOR_BASE + {11'h000, top_idx, 1'b0};
  // The counter runs from one up to CALL_CYCLES + JUMP_CYCLES and rests at zero otherwise.
  wire [4:0] cyc_nxt = (state_nxt == ST_RUN) ? 5'h00 : cyc_r + 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode.
  wire wr_global = reg_hit(reg_wr, reg_addr, ADDR_GLOBAL_EN);
  wire wr_ep = reg_hit(reg_wr, reg_addr, ADDR_EP_EN);
  wire wr_pen0 = reg_hit(reg_wr, reg_addr, ADDR_PIN_EN0);
  wire wr_pen1 = reg_hit(reg_wr, reg_addr, ADDR_PIN_EN1);
  wire wr_pol0 = reg_hit(reg_wr, reg_addr, ADDR_PIN_POL0);
  wire wr_pol1 = reg_hit(reg_wr, reg_addr, ADDR_PIN_POL1);
  wire wr_cap = reg_hit(reg_wr, reg_addr, ADDR_CAP_EN);
  // The pending bit in status is only meaningful while the global enable is off.
  wire status_pend = ~gie_r & (|pending_r);
  wire status_gie = gie_r;
  wire [7:0] status_byte = {status_pend, 4'h0, status_gie, 2'b00};
  // Pin enables and polarities are write-only and read back as zero.
  wire [7:0] rd_mux = (reg_addr == ADDR_GLOBAL_EN) ? global_en_r :
                      (reg_addr == ADDR_EP_EN) ? {5'h00, ep_en_r} :
                      (reg_addr == ADDR_CAP_EN) ? {4'h0, cap_en_r} :
                      (reg_addr == ADDR_STATUS) ? status_byte :
                      (reg_addr == ADDR_PENDING_LO) ? pending_r[7:0] :
                      (reg_addr == ADDR_PENDING_HI) ? {5'h00, pending_r[10:8]} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Pending flops: a new event wins over the clear done by acknowledge.
  always_comb begin
    pending_nxt = pending_r;
    if (take_now) begin
      pending_nxt[top_idx] = 1'b0;
    end
    pending_nxt = pending_nxt | src_event;
  end

  // Acknowledge walk: call phase then vector jump phase.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN: begin
        if (take_now) begin
          state_nxt = ST_CALL;
        end
      end
      ST_CALL: begin
        if (cyc_r == 5'(CALL_CYCLES)) begin
          state_nxt = ST_JUMP;
        end
      end
      ST_JUMP: begin
        if (cyc_r == 5'(CALL_CYCLES + JUMP_CYCLES)) begin
          state_nxt = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_RUN;
      cyc_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      global_en_r <= RESET_BYTE;
      ep_en_r <= 3'h0;
      pin_en_r <= '0;
      pin_pol_r <= '0;
      cap_en_r <= 4'h0;
    end else begin
      // Acknowledge never writes here, so pin enables survive servicing.
      if (wr_global) begin
        global_en_r <= reg_wdata;
      end
      if (wr_ep) begin
        ep_en_r <= reg_wdata[2:0];
      end
      if (wr_pen0) begin
        pin_en_r[7:0] <= reg_wdata;
      end
      if (wr_pen1) begin
        pin_en_r[15:8] <= reg_wdata;
      end
      if (wr_pol0) begin
        pin_pol_r[7:0] <= reg_wdata;
      end
      if (wr_pol1) begin
        pin_pol_r[15:8] <= reg_wdata;
      end
      if (wr_cap) begin
        cap_en_r <= reg_wdata[3:0];
      end
    end
  end

  // Global enable: acknowledge clears, return and enable set, disable clears.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gie_r <= 1'b0;
    end else if (take_now || disable_irq_instr) begin
      gie_r <= 1'b0;
    end else if (return_from_irq_instr || enable_irq_instr) begin
      gie_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pending_r <= '0;
    end else begin
      pending_r <= pending_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trig_lock_r <= '0;
    end else begin
      trig_lock_r <= lock_nxt;
    end
  end

  // The timer only runs while enabled, so a disabled timer draws no toggling power.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wake_cnt_r <= 32'h0;
    end else begin
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      take_r <= 1'b0;
      push_r_v <= 1'b0;
    end else begin
      take_r <= take_now;
      push_r_v <= take_now;
    end
  end

  // Vector and pushed state are captured on the acknowledge edge, so later flag changes cannot leak in.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vec_r <= RESET_PC;
      push_r <= 18'h00000;
    end else if (take_now) begin
      vec_r <= top_vec;
      push_r <= {carry_flag, zero_flag, cpu_pc};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata = rdata_r;
  assign irq_take = take_r;
  assign irq_vector = vec_r;
  assign fetch_pc = vec_r;
  assign stack_push_data = push_r;
  assign stack_push = push_r_v;
  assign restore_valid = return_from_irq_instr;
  assign restore_pc = stack_pop_data[15:0];
  assign restore_carry = stack_pop_data[17];
  assign restore_zero = stack_pop_data[16];
  assign ack_cycles = cyc_r;
  assign wake_running = global_en_r[WAKE_EN_BIT];
endmodule // irq_ctrl

// File: bench/irq_ctrl_assertions.sv
// Purpose: Port-level checks for the interrupt controller.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to the design from the bench top file.
`timescale 1ns/1ps
module irq_ctrl_assertions #(
  parameter int WAKE_CYC = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic instr_done,
  input wire logic [15:0] cpu_pc,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic [17:0] stack_pop_data,
  input wire logic irq_take,
  input wire logic [15:0] irq_vector,
  input wire logic [17:0] stack_push_data,
  input wire logic stack_push,
  input wire logic restore_valid,
  input wire logic [15:0] restore_pc,
  input wire logic restore_carry,
  input wire logic restore_zero,
  input wire logic [15:0] fetch_pc,
  input wire logic [4:0] ack_cycles,
  input wire logic wake_running
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  take_push_a: assert property (irq_take |-> stack_push && fetch_pc == irq_vector && ack_cycles == 5'h01)
    else $error("take without push or fetch address");
  take_boundary_a: assert property (irq_take |-> $past(instr_done))
    else $error("take away from an instruction end");
  vector_range_a: assert property (irq_take |-> !irq_vector[0] && irq_vector inside {[16'h0002:16'h0016]})
    else $error("vector outside table");
  ack_return_a: assert property (irq_take |-> ##14 ack_cycles == 5'h0f ##1 ack_cycles == 5'h00)
    else $error("acknowledge sequence too long");
  ack_busy_a: assert property (irq_take |=> (ack_cycles != 5'h00 && !irq_take) [*8])
    else $error("acknowledge sequence too short");
  restore_flags_a: assert property (restore_valid |-> {restore_carry, restore_zero, restore_pc} == stack_pop_data)
    else $error("restore differs from stack");
  push_data_a: assert property (stack_push |-> stack_push_data == {$past(carry_flag), $past(zero_flag), $past(cpu_pc)})
    else $error("pushed state differs from cpu state");
  wake_on_a: assert property (reg_wr && reg_addr == 8'h20 && reg_wdata[7] |=> wake_running)
    else $error("wake timer not started");
  wake_off_a: assert property (reg_wr && reg_addr == 8'h20 && !reg_wdata[7] |=> !wake_running)
    else $error("wake timer not stopped");
endmodule // irq_ctrl_assertions

// File: bench/cpu_model.sv
// Purpose: CPU sequencer stand-in with a program stack.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Eight stack entries; deeper nesting wraps, as a small stack would.
`timescale 1ns/1ps
module cpu_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [4:0] ack_cycles,
  input wire logic stack_push,
  input wire logic [17:0] stack_push_data,
  input wire logic return_from_irq_instr,
  output logic instr_done,
  output logic [15:0] cpu_pc,
  output logic carry_flag,
  output logic zero_flag,
  output logic [17:0] stack_pop_data
);
  logic [1:0] cnt_r;
  logic [2:0] sp_r;
  logic [17:0] stk_r [8];
  ////////////////////////////////////////
  assign instr_done = cnt_r == 2'h3 && ack_cycles == 5'h00;
  assign carry_flag = cpu_pc[0];
  assign zero_flag = cpu_pc[1];
  assign stack_pop_data = stk_r[sp_r - 3'h1];
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 2'h0;
      sp_r <= 3'h0;
      cpu_pc <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      if (instr_done) cpu_pc <= cpu_pc + 16'h0001;
      if (stack_push) begin
        stk_r[sp_r] <= stack_push_data;
        sp_r <= sp_r + 3'h1;
      end else if (return_from_irq_instr) sp_r <= sp_r - 3'h1;
    end
  end
endmodule // cpu_model

// File: bench/irq_ctrl_tb.sv
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: Stimulus moves just after rising edges.
// Notes: Checks sample at the falling edge so registered outputs have settled.
`timescale 1ns/1ps
module irq_ctrl_tb;
  import irq_ctrl_pkg::*;
  localparam int WAKE_CYC = 16;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [9:0] drv = 10'h000;
  logic [15:0] gp = 16'h0002;
  logic [1:0] cp = 2'b00;
  logic [7:0] reg_rdata;
  logic irq_take, stack_push, restore_valid, restore_carry, restore_zero, wake_running;
  logic [15:0] irq_vector, restore_pc, fetch_pc, cpu_pc;
  logic [17:0] stack_push_data, stack_pop_data;
  logic [4:0] ack_cycles;
  logic instr_done, carry_flag, zero_flag;
  int n_fail = 0;
  int comparisons = 0;
  ////////////////////////////////////////
  irq_ctrl #(.WAKE_CYC(WAKE_CYC)) dut (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bus_event(drv[0]), .tick_128us(drv[1]), .tick_1024us(drv[2]), .ep_event(drv[5:3]), .spi_event(drv[6]),
    .gpio_pin(gp), .cap_pin(cp), .instr_done, .disable_irq_instr(drv[7]), .enable_irq_instr(drv[8]),
    .return_from_irq_instr(drv[9]), .cpu_pc, .carry_flag, .zero_flag, .stack_pop_data, .irq_take,
    .irq_vector, .stack_push_data, .stack_push, .restore_valid, .restore_pc, .restore_carry,
    .restore_zero, .fetch_pc, .ack_cycles, .wake_running);
  cpu_model cpu (.ref_clk, .nrst, .ack_cycles, .stack_push, .stack_push_data,
    .return_from_irq_instr(drv[9]), .instr_done, .cpu_pc, .carry_flag, .zero_flag, .stack_pop_data);
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    end_of_test();
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    cmp({8'h00, reg_rdata & m}, {8'h00, e});
  endtask
  task automatic pulse(input logic [9:0] m);
    @(posedge ref_clk);
    drv <= m;
    @(posedge ref_clk);
    drv <= 10'h000;
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      cmp(16'(irq_take), 16'h0000);
    end
  endtask
  task automatic take(input logic [15:0] v);
    int k;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (irq_take !== 1'b1 && k < 80);
    if (irq_take !== 1'b1) hang();
    cmp(irq_vector, v);
  endtask
  task automatic ret;
    int k;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (ack_cycles !== 5'h00 && k < 40);
    if (ack_cycles !== 5'h00) hang();
    pulse(10'h200);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    cmp(fetch_pc, RESET_PC);
    rd(ADDR_GLOBAL_EN, 8'h00, 8'hff);
    rd(ADDR_STATUS, 8'h00, 8'hff);
    wr(ADDR_GLOBAL_EN, 8'h0f);
    wr(ADDR_EP_EN, 8'h07);
    pulse(10'h07f);
    quiet(12);
    rd(ADDR_STATUS, 8'h80, 8'hff);
    rd(ADDR_PENDING_LO, 8'h7f, 8'hff);
    pulse(10'h100);
    for (int i = 0; i < 7; i++) begin
      take(VECTOR_BASE + 16'(2 * i));
      if (i == 0) rd(ADDR_STATUS, 8'h80, 8'hff);
      ret();
    end
    rd(ADDR_STATUS, 8'h04, 8'hff);
    rd(ADDR_PENDING_LO, 8'h00, 8'hff);
    wr(ADDR_GLOBAL_EN, 8'h00);
    pulse(10'h040);
    quiet(12);
    rd(ADDR_PENDING_LO, 8'h40, 8'hff);
    wr(ADDR_GLOBAL_EN, 8'h08);
    take(16'h000e);
    ret();
    pulse(10'h080);
    rd(ADDR_STATUS, 8'h00, 8'h04);
    rd(ADDR_GLOBAL_EN, 8'h08, 8'hff);
    pulse(10'h100);
    wr(ADDR_GLOBAL_EN, 8'h40);
    wr(ADDR_PIN_EN0, 8'h03);
    wr(ADDR_PIN_POL0, 8'h01);
    @(posedge ref_clk) gp <= 16'h0003;
    take(16'h0014);
    ret();
    @(posedge ref_clk) gp <= 16'h0001;
    quiet(16);
    @(posedge ref_clk) gp <= 16'h0002;
    @(posedge ref_clk) gp <= 16'h0000;
    take(16'h0014);
    wr(ADDR_GLOBAL_EN, 8'h00);
    ret();
    wr(ADDR_CAP_EN, 8'h02);
    rd(ADDR_CAP_EN, 8'h02, 8'hff);
    wr(ADDR_GLOBAL_EN, 8'h10);
    @(posedge ref_clk) cp <= 2'b01;
    quiet(12);
    @(posedge ref_clk) cp <= 2'b00;
    take(16'h0010);
    ret();
    wr(ADDR_GLOBAL_EN, 8'h80);
    take(16'h0016);
    wr(ADDR_GLOBAL_EN, 8'h00);
    ret();
    quiet(60);
    cmp(16'(wake_running), 16'h0000);
    end_of_test();
  end
endmodule // irq_ctrl_tb
bind irq_ctrl irq_ctrl_assertions #(.WAKE_CYC(WAKE_CYC)) chk (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .instr_done, .cpu_pc, .carry_flag, .zero_flag, .stack_pop_data, .irq_take, .irq_vector, .stack_push_data,
  .stack_push, .restore_valid, .restore_pc, .restore_carry, .restore_zero, .fetch_pc, .ack_cycles, .wake_running);
